// ### core/optc_pkg.sv
// Contract
// R1: reading counter_readback returns the live 16-bit count, counting undisturbed.
// R2: one-shot delay is compare-1 clocks, width compare-0 minus compare-1 plus one.
// R3: one-shot makes no pulse when compare-1 exceeds compare-0.
// R4: software halts counting before lowering a compare value in one-shot mode.
// R5: one-shot compare writes act at once; a passed value matches after wrap.
// R6: one-shot compare-1 match raises irq and pin; compare-0 match irq, drops, stops.
// R7: one-shot compare-1 irq fires in the cycle the count equals compare-1.
// R8: PWM mode with count enable drives a PWM waveform on the second pin.
// R9: in PWM the first pin toggles at each period boundary.
// R10: count enable in PWM steps counter FFFFH to 0000H and starts output.
// R11: PWM period is compare-0 plus one clocks, active width compare-1 clocks.
// R12: PWM shadows load from compare registers only when the counter clears.
// R13: PWM compare-0 irq comes on the clock after the match, with the clear.
// R14: PWM compare-1 irq fires in the cycle the count equals compare-1 shadow.
// R15: pin output control holds per-pin enables, first pin idle level, second polarity.
// R16: software keeps the first pin enable at zero when unused in PWM.
// R17: edge select control holds event edge and trigger edge fields.
// R18: capture input control and option register have no effect in these modes.
// R19: one-shot mode 011 waits for a trigger, pulses, returns to FFFFH, waits.
// R20: triggers are external edge or software bit; ignored while pulse runs.
// R21: clearing count enable stops the counter at FFFFH, pins go inactive.
package optc_pkg;
    localparam logic [7:0]  OFF_CTL0   = 8'h00;
    localparam logic [7:0]  OFF_CTL1   = 8'h04;
    localparam logic [7:0]  OFF_PINCTL = 8'h08;
    localparam logic [7:0]  OFF_CAPCTL = 8'h0C;
    localparam logic [7:0]  OFF_EDGE   = 8'h10;
    localparam logic [7:0]  OFF_OPT    = 8'h14;
    localparam logic [7:0]  OFF_CMP0   = 8'h18;
    localparam logic [7:0]  OFF_CMP1   = 8'h1C;
    localparam logic [7:0]  OFF_CNT    = 8'h20;
    localparam int          CE_BIT     = 0;
    localparam int          PSC_LSB    = 1;
    localparam int          MODE_LSB   = 0;
    localparam int          SWTRIG_BIT = 3;
    localparam int          TRG_RISE   = 0;
    localparam int          TRG_FALL   = 1;
    localparam logic [2:0]  MODE_ONESHOT = 3'h3;
    localparam logic [2:0]  MODE_PWM     = 3'h4;
    localparam logic [15:0] CNT_IDLE   = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] RST_CMP    = 16'h0000;
    localparam logic [7:0]  RST_CTL    = 8'h00;
    localparam logic [6:0]  RST_DIV    = 7'h00;

    typedef struct packed {
        logic [3:0] rsv;
        logic       pol1;
        logic       oe1;
        logic       lvl0;
        logic       oe0;
    } optc_pinctl_t;

    typedef struct packed {
        logic out;
        logic oe;
    } optc_pin_t;

    typedef enum logic [0:0] {ST_IDLE, ST_RUN} optc_state_t;
endpackage

// ### core/optc_timer_channel.sv
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module optc_timer_channel (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              ext_trigger,
    output optc_pkg::optc_pin_t    first_channel_pin,
    output optc_pkg::optc_pin_t    second_channel_pin,
    output logic                   compare_zero_interrupt,
    output logic                   compare_one_interrupt
);
    // address match helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic [7:0]                ctl0_ff;
    logic [7:0]                ctl1_ff;
    optc_pkg::optc_pinctl_t    pinctl_ff;
    logic [7:0]                capctl_ff;
    logic [7:0]                edge_ff;
    logic [7:0]                opt_ff;
    logic [15:0]               cmp0_ff;
    logic [15:0]               cmp1_ff;
    logic [15:0]               counter_ff;
    logic [15:0]               sh0_ff;
    logic [15:0]               sh1_ff;
    optc_pkg::optc_state_t     state_ff;
    logic                      act_ff;
    logic                      tog_ff;
    logic                      trig_ff;
    logic                      reload_ff;
    logic                      cc0_ff;
    logic                      cc1_ff;
    logic [6:0]                div_ff;
    logic                      trg_s1_ff;
    logic                      trg_s2_ff;
    logic                      trg_d_ff;
    logic                      wr_ff;
    logic [7:0]                wa_ff;
    logic [31:0]               rdata_ff;
    optc_pkg::optc_pin_t       pin0_ff;
    optc_pkg::optc_pin_t       pin1_ff;

    default clocking dcb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // bus handshake: zero wait, always okay
    wire        take    = hsel & htrans[1] & hready;
    wire        rd_take = take & ~hwrite;
    wire        wr_cmp1 = wr_ff & hit(wa_ff, optc_pkg::OFF_CMP1);
    wire        sw_hit  = wr_ff & hit(wa_ff, optc_pkg::OFF_CTL1)
                          & hwdata[optc_pkg::SWTRIG_BIT];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;

    // mode and enable decode
    wire        ce  = ctl0_ff[optc_pkg::CE_BIT];
    wire [2:0]  md  = ctl1_ff[optc_pkg::MODE_LSB +: 3];
    wire        os  = md == optc_pkg::MODE_ONESHOT;
    wire        pwm = md == optc_pkg::MODE_PWM;
    wire        run = state_ff == optc_pkg::ST_RUN;

    // count clock from the prescaler
    wire [2:0]  psc  = ctl0_ff[optc_pkg::PSC_LSB +: 3];
    wire [7:0]  pm8  = (8'h01 << psc) - 8'h01;
    wire [6:0]  pm   = pm8[6:0];
    wire        tick = (div_ff & pm) == pm;

    // trigger edge detect on the synchronised pin
    wire        rise     = trg_s2_ff & ~trg_d_ff;
    wire        fall     = ~trg_s2_ff & trg_d_ff;
    wire        trig_hit = (edge_ff[optc_pkg::TRG_RISE] & rise)
                           | (edge_ff[optc_pkg::TRG_FALL] & fall);

    // address phase capture and register reads
    logic [31:0] rd_c;
    always_comb
    begin
        rd_c = 32'h0000_0000;
        if (hit(haddr[7:0], optc_pkg::OFF_CTL0))
            rd_c = {24'h00_0000, ctl0_ff};
        else if (hit(haddr[7:0], optc_pkg::OFF_CTL1))
            rd_c = {24'h00_0000, ctl1_ff & 8'hF7}; // trigger bit reads zero
        else if (hit(haddr[7:0], optc_pkg::OFF_PINCTL))
            rd_c = {24'h00_0000, 4'h0, pinctl_ff[3:0]};
        else if (hit(haddr[7:0], optc_pkg::OFF_CAPCTL))
            rd_c = {24'h00_0000, capctl_ff};
        else if (hit(haddr[7:0], optc_pkg::OFF_EDGE))
            rd_c = {24'h00_0000, edge_ff};
        else if (hit(haddr[7:0], optc_pkg::OFF_OPT))
            rd_c = {24'h00_0000, opt_ff};
        else if (hit(haddr[7:0], optc_pkg::OFF_CMP0))
            rd_c = {16'h0000, cmp0_ff};
        else if (hit(haddr[7:0], optc_pkg::OFF_CMP1))
            rd_c = {16'h0000, cmp1_ff};
        else if (hit(haddr[7:0], optc_pkg::OFF_CNT))
            rd_c = {16'h0000, counter_ff}; // R1
    end

    // bus phase registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ff    <= 1'b0;
            wa_ff    <= 8'h00;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            wr_ff <= take & hwrite;
            wa_ff <= haddr[7:0];
            if (rd_take)
                rdata_ff <= rd_c; // R1
        end
    end

    property p_readback;
        rd_take && hit(haddr[7:0], optc_pkg::OFF_CNT) |=> hrdata[15:0] == $past(counter_ff);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch"); // R1

    // register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl0_ff   <= optc_pkg::RST_CTL;
            ctl1_ff   <= optc_pkg::RST_CTL;
            pinctl_ff <= optc_pkg::RST_CTL;
            capctl_ff <= optc_pkg::RST_CTL;
            edge_ff   <= optc_pkg::RST_CTL;
            opt_ff    <= optc_pkg::RST_CTL;
            cmp0_ff   <= optc_pkg::RST_CMP;
            cmp1_ff   <= optc_pkg::RST_CMP;
        end
        else if (wr_ff)
        begin
            if (hit(wa_ff, optc_pkg::OFF_CTL0))
                ctl0_ff <= hwdata[7:0];
            else if (hit(wa_ff, optc_pkg::OFF_CTL1))
                ctl1_ff <= hwdata[7:0] & 8'hF7;
            else if (hit(wa_ff, optc_pkg::OFF_PINCTL))
                pinctl_ff <= {4'h0, hwdata[3:0]}; // R15
            else if (hit(wa_ff, optc_pkg::OFF_CAPCTL))
                capctl_ff <= hwdata[7:0]; // R18
            else if (hit(wa_ff, optc_pkg::OFF_EDGE))
                edge_ff <= hwdata[7:0]; // R17
            else if (hit(wa_ff, optc_pkg::OFF_OPT))
                opt_ff <= hwdata[7:0]; // R18
            else if (hit(wa_ff, optc_pkg::OFF_CMP0))
                cmp0_ff <= hwdata[15:0];
            else if (hit(wa_ff, optc_pkg::OFF_CMP1))
                cmp1_ff <= hwdata[15:0];
        end
    end

    // counter, shadows and pulse state
    optc_pkg::optc_state_t nxt_state;
    logic [15:0] nxt_counter;
    logic [15:0] nxt_sh0;
    logic [15:0] nxt_sh1;
    logic        nxt_act;
    logic        nxt_tog;
    logic        nxt_trig;
    logic        nxt_reload;
    logic        nxt_cc0;
    logic        nxt_cc1;
    logic        step;
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_counter = counter_ff;
        nxt_sh0     = sh0_ff;
        nxt_sh1     = sh1_ff;
        nxt_tog     = tog_ff;
        nxt_reload  = reload_ff | wr_cmp1; // set wins over clear
        nxt_cc0     = 1'b0;
        step        = 1'b0;
        nxt_trig    = 1'b0;
        if (!ce || !(os || pwm))
        begin
            nxt_state   = optc_pkg::ST_IDLE; // R21
            nxt_counter = optc_pkg::CNT_IDLE; // R21
            nxt_tog     = 1'b0;
            nxt_reload  = 1'b0;
        end
        else
        begin
            case (state_ff)
                optc_pkg::ST_IDLE:
                begin
                    if (os)
                        nxt_trig = (trig_ff & ~tick) | trig_hit | sw_hit; // R20
                    if (tick && (pwm || trig_ff))
                    begin
                        nxt_state   = optc_pkg::ST_RUN; // R10 R19
                        nxt_counter = optc_pkg::CNT_ZERO; // R10
                        nxt_sh0     = cmp0_ff;
                        nxt_sh1     = cmp1_ff;
                        nxt_reload  = wr_cmp1;
                        step        = 1'b1;
                    end
                end
                optc_pkg::ST_RUN:
                begin
                    if (tick && os && counter_ff == cmp0_ff)
                    begin
                        nxt_state   = optc_pkg::ST_IDLE; // R6 R19
                        nxt_counter = optc_pkg::CNT_IDLE; // R19
                        nxt_cc0     = 1'b1; // R6
                    end
                    else if (tick && pwm && counter_ff == sh0_ff)
                    begin
                        nxt_counter = optc_pkg::CNT_ZERO; // R11
                        nxt_cc0     = 1'b1; // R13
                        nxt_tog     = ~tog_ff; // R9
                        step        = 1'b1;
                        if (reload_ff)
                        begin
                            nxt_sh0    = cmp0_ff; // R12
                            nxt_sh1    = cmp1_ff; // R12
                            nxt_reload = wr_cmp1;
                        end
                    end
                    else if (tick)
                    begin
                        nxt_counter = counter_ff + 16'h0001; // R5
                        step        = 1'b1;
                    end
                end
                default:
                    nxt_state = optc_pkg::ST_IDLE;
            endcase
        end
    end

    // pin level and compare-1 event from the next count
    wire nrun   = nxt_state == optc_pkg::ST_RUN;
    wire os_eq1 = step && nxt_counter == cmp1_ff; // R5 R7
    wire pw_eq1 = step && nxt_counter == nxt_sh1; // R14
    assign nxt_cc1 = nrun && (os ? os_eq1 : pwm && pw_eq1);
    assign nxt_act = !nrun ? 1'b0 :
                     os ? (act_ff | os_eq1) : // R2 R3 R6
                     (nxt_counter < nxt_sh1); // R8 R11

    // pins: first pin enable gates its level, polarity flips the second pin
    wire lvl0 = pinctl_ff.lvl0;
    wire p0   = pinctl_ff.oe0 ? (lvl0 ^ (pwm ? nxt_tog : nrun)) : lvl0; // R9 R15
    wire p1   = nxt_act ^ pinctl_ff.pol1; // R15

    // state registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff   <= optc_pkg::ST_IDLE;
            counter_ff <= optc_pkg::CNT_IDLE;
            sh0_ff     <= optc_pkg::RST_CMP;
            sh1_ff     <= optc_pkg::RST_CMP;
            act_ff     <= 1'b0;
            tog_ff     <= 1'b0;
            trig_ff    <= 1'b0;
            reload_ff  <= 1'b0;
            cc0_ff     <= 1'b0;
            cc1_ff     <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            counter_ff <= nxt_counter;
            sh0_ff     <= nxt_sh0;
            sh1_ff     <= nxt_sh1;
            act_ff     <= nxt_act;
            tog_ff     <= nxt_tog;
            trig_ff    <= nxt_trig;
            reload_ff  <= nxt_reload;
            cc0_ff     <= nxt_cc0;
            cc1_ff     <= nxt_cc1;
        end
    end

    // prescaler, trigger synchroniser and pin registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_ff    <= optc_pkg::RST_DIV;
            trg_s1_ff <= 1'b0;
            trg_s2_ff <= 1'b0;
            trg_d_ff  <= 1'b0;
            pin0_ff   <= 2'b00;
            pin1_ff   <= 2'b00;
        end
        else
        begin
            div_ff    <= ce ? div_ff + 7'h01 : optc_pkg::RST_DIV;
            trg_s1_ff <= ext_trigger;
            trg_s2_ff <= trg_s1_ff;
            trg_d_ff  <= trg_s2_ff;
            pin0_ff   <= '{out: p0, oe: pinctl_ff.oe0};
            pin1_ff   <= '{out: p1, oe: pinctl_ff.oe1};
        end
    end

    assign first_channel_pin      = pin0_ff;
    assign second_channel_pin     = pin1_ff;
    assign compare_zero_interrupt = cc0_ff;
    assign compare_one_interrupt  = cc1_ff;

    // one-shot end and step, PWM start and wrap sequences
    sequence s_os_end;
        os && run && tick && counter_ff == cmp0_ff;
    endsequence
    sequence s_os_step;
        os && run && tick && counter_ff != cmp0_ff;
    endsequence
    sequence s_pwm_go;
        pwm && ce && !run && tick;
    endsequence
    sequence s_pwm_wrap;
        pwm && ce && run && tick && counter_ff == sh0_ff;
    endsequence

    property p_os_stop;
        s_os_end |=> counter_ff == optc_pkg::CNT_IDLE && compare_zero_interrupt
                     && !run && !act_ff;
    endproperty
    a_os_stop: assert property (p_os_stop) else $error("one-shot stop wrong"); // R6

    property p_os_step;
        (s_os_step and ce) |=> run && counter_ff == $past(counter_ff) + 16'h0001;
    endproperty
    a_os_step: assert property (p_os_step) else $error("one-shot step wrong"); // R5

    property p_os_rise;
        os && $rose(act_ff) |-> counter_ff == cmp1_ff && compare_one_interrupt;
    endproperty
    a_os_rise: assert property (p_os_rise) else $error("pulse start off"); // R7

    property p_pwm_start;
        s_pwm_go |=> run && counter_ff == optc_pkg::CNT_ZERO;
    endproperty
    a_pwm_start: assert property (p_pwm_start) else $error("pwm start wrong"); // R10

    property p_pwm_clear;
        s_pwm_wrap |=> counter_ff == optc_pkg::CNT_ZERO && compare_zero_interrupt
                       && tog_ff != $past(tog_ff);
    endproperty
    a_pwm_clear: assert property (p_pwm_clear) else $error("pwm clear wrong"); // R13

    property p_pwm_level;
        pwm && run && $stable(md) |-> act_ff == (counter_ff < sh1_ff);
    endproperty
    a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong"); // R11

    property p_pwm_cc1;
        pwm && compare_one_interrupt |-> counter_ff == sh1_ff;
    endproperty
    a_pwm_cc1: assert property (p_pwm_cc1) else $error("cc1 misplaced"); // R14

    property p_reload;
        pwm && run && !(tick && counter_ff == sh0_ff) |=> $stable(sh0_ff) && $stable(sh1_ff);
    endproperty
    a_reload: assert property (p_reload) else $error("shadow changed"); // R12

    property p_stop;
        !ce |=> counter_ff == optc_pkg::CNT_IDLE && !act_ff && !run;
    endproperty
    a_stop: assert property (p_stop) else $error("stop state wrong"); // R21
endmodule // optc_timer_channel

// ### verification/optc_timer_channel_tb.sv
`timescale 1ns/1ps
module optc_timer_channel_tb;
    typedef struct packed {
        logic [2:0]  psc;
        logic        pol;
        logic [15:0] cmp0;
        logic [15:0] cmp1;
        int          n;
        int          act;
        int          c0;
        int          c1;
        int          e1;
    } optc_row_t;

    logic                hclk;
    logic                hresetn;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    logic                hready;
    logic                hresp;
    logic [31:0]         hrdata;
    logic                ext_trigger;
    optc_pkg::optc_pin_t pin0;
    optc_pkg::optc_pin_t pin1;
    logic                cc0;
    logic                cc1;
    logic                p0_q;
    logic                p1_q;
    logic                pol;
    logic [31:0]         rd;
    int                  num_errors;
    int                  n_checks;
    int                  act, c0, c1, e1, tog, t_p0, t_c1, t_c0, k;
    optc_row_t           rows [4];
    logic [7:0]          ra [9];
    logic [31:0]         rw [9];
    logic [31:0]         rx [9];

    // device under test, zero-wait slave drives its own hready
    optc_timer_channel dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .ext_trigger(ext_trigger), .first_channel_pin(pin0),
        .second_channel_pin(pin1), .compare_zero_interrupt(cc0),
        .compare_one_interrupt(cc1)
    );

    // 40 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // pin levels of the previous cycle, for edge detection
    always @(posedge hclk)
    begin
        p0_q <= pin0.out;
        p1_q <= pin1.out;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // wait for hready at a rising edge, bounded
    task automatic edge_wait();
        for (int i = 0; i < 50; i++)
        begin
            @(posedge hclk);
            if (hready === 1'b1)
                return;
        end
        num_errors++;
        give_verdict();
    endtask

    // one single AHB transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        edge_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_wait();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // wait for one interrupt pulse, bounded; returns inside its cycle
    task automatic wait_irq(input logic one);
        for (int i = 0; i < 200; i++)
        begin
            @(posedge hclk);
            #1;
            if ((one ? cc1 : cc0) === 1'b1)
                return;
        end
        num_errors++;
        give_verdict();
    endtask

    // count pin activity and interrupts over n cycles
    task automatic watch(input int n);
        act = 0; c0 = 0; c1 = 0; e1 = 0; tog = 0; t_p0 = -1; t_c1 = -1; t_c0 = -1;
        for (int i = 0; i < n; i++)
        begin
            #1;
            act += int'((pin1.out ^ pol) === 1'b1);
            c0 += int'(cc0 === 1'b1);
            c1 += int'(cc1 === 1'b1);
            e1 += int'(cc1 === 1'b1 && pin1.out !== p1_q);
            if (pin0.out !== p0_q)
            begin
                tog++;
                if (t_p0 < 0) t_p0 = i;
            end
            if (cc1 === 1'b1 && t_c1 < 0) t_c1 = i;
            if (cc0 === 1'b1 && t_c0 < 0) t_c0 = i;
            @(posedge hclk);
        end
    endtask

    // main sequence
    initial
    begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; ext_trigger = 1'b0; pol = 1'b0;
        num_errors = 0; n_checks = 0;
        rows[0] = '{3'h0, 1'b0, 16'h0003, 16'h0001, 8, 2, 2, 2, 2};
        rows[1] = '{3'h1, 1'b0, 16'h0003, 16'h0001, 16, 4, 2, 2, 2};
        rows[2] = '{3'h0, 1'b1, 16'h0004, 16'h0005, 10, 10, 2, 0, 0};
        rows[3] = '{3'h0, 1'b0, 16'h0002, 16'h0000, 6, 0, 2, 2, 0};
        ra = '{optc_pkg::OFF_CMP0, optc_pkg::OFF_CMP1, optc_pkg::OFF_PINCTL,
               optc_pkg::OFF_EDGE, optc_pkg::OFF_CAPCTL, optc_pkg::OFF_OPT,
               optc_pkg::OFF_CNT, 8'h40, optc_pkg::OFF_CTL1};
        rw = '{32'h1234A5A5, 32'hFFFF5A5A, 32'h0A, 32'h0D, 32'h03, 32'h05,
               32'h1234, 32'hFFFFFFFF, 32'h08};
        rx = '{32'hA5A5, 32'h5A5A, 32'h0A, 32'h0D, 32'h03, 32'h05,
               32'hFFFF, 32'h0, 32'h0};
        repeat (8) @(posedge hclk);
        #1;
        check({pin0, pin1, cc0, cc1, hresp}, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, optc_pkg::OFF_CNT, 32'h0);
        check(rd, 32'hFFFF);
        // register storage, read-only counter, unmapped hole
        for (int i = 0; i < 9; i++)
        begin
            wr(ra[i], rw[i]);
            bus(1'b0, ra[i], 32'h0);
            check(rd, rx[i]);
        end
        // pwm table, capture and option registers left nonzero
        foreach (rows[i])
        begin
            pol = rows[i].pol;
            wr(optc_pkg::OFF_CTL0, 32'h0);
            wr(optc_pkg::OFF_PINCTL, {28'h0, rows[i].pol, 3'h5});
            wr(optc_pkg::OFF_CMP0, {16'h0, rows[i].cmp0});
            wr(optc_pkg::OFF_CMP1, {16'h0, rows[i].cmp1});
            wr(optc_pkg::OFF_CTL1, {29'h0, optc_pkg::MODE_PWM});
            wr(optc_pkg::OFF_CTL0, {28'h0, rows[i].psc, 1'b1});
            wait_irq(1'b0);
            watch(rows[i].n);
            check(act, rows[i].act);
            check(c0, rows[i].c0);
            check(c1, rows[i].c1);
            check(e1, rows[i].e1);
            check(tog, rows[i].c0);
        end
        // start from idle, then shadow reload only after compare_one write
        pol = 1'b0;
        wr(optc_pkg::OFF_CTL0, 32'h0);
        wr(optc_pkg::OFF_PINCTL, 32'h05);
        wr(optc_pkg::OFF_CMP0, 32'h3);
        wr(optc_pkg::OFF_CMP1, 32'h1);
        wr(optc_pkg::OFF_CTL0, 32'h1);
        watch(8);
        check(t_c1, 2);
        check(t_c0, 5);
        bus(1'b0, optc_pkg::OFF_CNT, 32'h0);
        check(rd[31:2], 30'h0);
        wr(optc_pkg::OFF_CMP0, 32'h5);
        wait_irq(1'b0);
        wait_irq(1'b0);
        watch(12);
        check(c0, 3);
        wr(optc_pkg::OFF_CMP1, 32'h2);
        wait_irq(1'b0);
        wait_irq(1'b0);
        watch(12);
        check(act, 4);
        check(c0, 2);
        // stop, idle levels and polarity
        wr(optc_pkg::OFF_CTL0, 32'h0);
        wr(optc_pkg::OFF_PINCTL, 32'h0E);
        @(posedge hclk);
        #1;
        check({pin0, pin1}, 32'hB);
        bus(1'b0, optc_pkg::OFF_CNT, 32'h0);
        check(rd, 32'hFFFF);
        wr(optc_pkg::OFF_PINCTL, 32'h05);
        @(posedge hclk);
        #1;
        check({pin0, pin1}, 32'h5);
        // one-shot: wait for trigger, timed pulse
        wr(optc_pkg::OFF_CTL1, {29'h0, optc_pkg::MODE_ONESHOT});
        wr(optc_pkg::OFF_CTL0, 32'h1);
        watch(6);
        check(tog + c0, 0);
        wr(optc_pkg::OFF_CTL1, {28'h0, 1'b1, optc_pkg::MODE_ONESHOT});
        watch(16);
        check(t_c1 - t_p0, 2);
        check(t_c0 - t_c1, 4);
        check(act, 4);
        check(e1, 1);
        check(c0, 1);
        check(tog, 2);
        bus(1'b0, optc_pkg::OFF_CNT, 32'h0);
        check(rd, 32'hFFFF);
        // second trigger during the pulse is dropped
        wr(optc_pkg::OFF_CTL1, {28'h0, 1'b1, optc_pkg::MODE_ONESHOT});
        wr(optc_pkg::OFF_CTL1, {28'h0, 1'b1, optc_pkg::MODE_ONESHOT});
        watch(20);
        check(c0, 1);
        // external trigger on each selectable edge
        for (int s = 0; s < 2; s++)
        begin
            wr(optc_pkg::OFF_EDGE, (s == 0) ? 32'h1 : 32'h2);
            ext_trigger <= 1'b1;
            watch(20);
            check(c0, int'(s == 0));
            ext_trigger <= 1'b0;
            watch(20);
            check(c0, int'(s == 1));
        end
        // compare_one above compare_zero gives no pulse
        wr(optc_pkg::OFF_CMP1, 32'h6);
        wr(optc_pkg::OFF_CTL1, {28'h0, 1'b1, optc_pkg::MODE_ONESHOT});
        watch(20);
        check(act + c1, 0);
        // lowering compare_zero mid-pulse: match only after wrap
        wr(optc_pkg::OFF_CMP1, 32'h2);
        wr(optc_pkg::OFF_CTL1, {28'h0, 1'b1, optc_pkg::MODE_ONESHOT});
        wait_irq(1'b1);
        wr(optc_pkg::OFF_CMP0, 32'h1);
        for (k = 0; k < 70000; k++)
        begin
            @(posedge hclk);
            #1;
            if (cc0 === 1'b1)
                break;
        end
        check(int'(k > 65000 && k < 65540), 1);
        // reset in mid-run
        wr(optc_pkg::OFF_CTL1, {29'h0, optc_pkg::MODE_PWM});
        wr(optc_pkg::OFF_CTL0, 32'h1);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b0;
        #1;
        check({pin0, pin1, cc0, cc1}, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, optc_pkg::OFF_CMP0, 32'h0);
        check(rd, 32'h0);
        give_verdict();
    end
endmodule // optc_timer_channel_tb
